// File: testbench/carriage_sensor_model.sv
`timescale 1ns/1ps
module carriage_sensor_model
    import carriage_gap_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Drives from the block.
    input  wire motor_out_t motor_i,
    input  wire logic       edge_emitter_i,
    // Sensor outputs.
    output logic            carriage_home_sensor_o,
    output logic            enc_a_o,
    output logic            enc_b_o,
    output logic            head_gap_home_sensor_o,
    output logic [7:0]      edge_adc_o,
    output logic            edge_adc_valid_o
);
    int         pos_q = -8;
    int         cam_q = 5;
    logic       paper = 1'b0;
    logic       step_q = 1'b0;
    logic [3:0] tick_q = 4'h0;
    logic [7:0] noise_q = 8'h00;

    initial
    begin
        edge_adc_valid_o = 1'b0;
    end

    // The flag is inside the home range for negative positions, where the sensor reads low.
    assign carriage_home_sensor_o = (pos_q >= 0);
    // Gray sequence so exactly one channel changes per count.
    assign enc_a_o = pos_q[1];
    assign enc_b_o = pos_q[1] ^ pos_q[0];
    // The cam flag is seen once per cam round of 333 steps.
    assign head_gap_home_sensor_o = (cam_q % 333 == 0);

    // The cam turns only on reverse steps, as the gear engages at home.
    always @(posedge clk_i)
    begin
        step_q <= motor_i.step_pulse;
        if (motor_i.step_reverse && motor_i.step_pulse && !step_q)
            cam_q <= cam_q + 1;
    end

    // A sample every 16 cycles; between samples the bus toggles so stale data never matches.
    // The sample follows the emitter level that the block holds while it takes the strobe.
    always @(posedge clk_i)
    begin
        tick_q <= tick_q + 4'h1;
        edge_adc_valid_o <= (tick_q == 4'hF);
        noise_q <= ~noise_q;
    end
    assign edge_adc_o = !edge_adc_valid_o ? noise_q :
                        edge_emitter_i ? (paper ? 8'hD0 : 8'h50) : 8'h10;

    // Moves the carriage by n encoder counts, one count every 8 cycles.
    task automatic move(input int n);
        int k;
        for (k = 0; k < (n < 0 ? -n : n); k++)
        begin
            repeat (8) @(posedge clk_i);
            pos_q <= pos_q + (n < 0 ? -1 : 1);
        end
    endtask : move
endmodule : carriage_sensor_model

// File: testbench/test_carriage_gap_position_logic.sv
`timescale 1ns/1ps
module test_carriage_gap_position_logic
    import carriage_gap_pkg::*;
;
    typedef struct packed {logic chk; logic [31:0] msk; logic [31:0] val;} note_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, irq_o, emit, print_timing_pulse, fire, home, enc_a, enc_b, gap_home, adc_v;
    logic [7:0]  adc;
    motor_out_t  motor_o;
    note_t       notes[$];
    note_t       note;
    integer      seed = 32'h0290;
    int          fails = 0, n_tests = 0, cycles = 0, pts_n = 0, toggles = 0;
    int          fire_at = 0, fire_gap = 0;
    logic        em_q = 1'b0;
    logic [31:0] p0, p1, tgt;
    logic [15:0] d;
    int          a;

    carriage_gap_position_logic carriage_gap_position_logic_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq_o(irq_o), .carriage_home_sensor_i(home), .enc_a_i(enc_a), .enc_b_i(enc_b),
        .head_gap_home_sensor_i(gap_home), .edge_adc_i(adc), .edge_adc_valid_i(adc_v),
        .edge_emitter_o(emit), .print_timing_pulse_o(print_timing_pulse), .motor_o(motor_o),
        .waveform_fire_o(fire));
    carriage_sensor_model carriage_sensor_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .motor_i(motor_o), .edge_emitter_i(emit), .carriage_home_sensor_o(home),
        .enc_a_o(enc_a), .enc_b_o(enc_b), .head_gap_home_sensor_o(gap_home),
        .edge_adc_o(adc), .edge_adc_valid_o(adc_v));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, cycle limit and output watchers.
    always #4 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        cycles++;
        em_q <= emit;
        if (emit !== em_q)
            toggles++;
        if (print_timing_pulse === 1'b1)
            pts_n++;
        // Distance between the last two firing pulses.
        if (fire === 1'b1)
        begin
            fire_gap = cycles - fire_at;
            fire_at = cycles;
        end
        if (wb_ack_o === 1'b1 && notes.size() > 0)
        begin
            note = notes.pop_front();
            if (note.chk)
                check("read data", note.val, wb_dat_o & note.msk);
        end
        if (cycles == 90000)
        begin
            fails++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One classic cycle; the request stays put until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                       input note_t n, output logic [31:0] q);
        int k;
        notes.push_back(n);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= ad;
        wb_dat <= wd;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o;
        if (k >= 50)
            check("ack", 32'h1, 32'h0);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        bus(1'b1, ad, wd, '0, p1);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, ad, 32'h0, '{1'b1, m, e}, p1);
    endtask : rd

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTRL_OFS, 32'hFFFF_FFFF, CTRL_RST);
        rd(EDGE_CFG_OFS, 32'hFF, {24'h0, THRESH_RST});
        rd(STATUS_OFS, 32'hFFFF_FFFF, 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'hFFFF_FFFF, 32'h0);
        $display("test reset done");
        // Leaving home raises the enabled home event. Clearing drops the level.
        wr(IRQ_EN_OFS, 32'h1 << EV_HOME);
        carriage_sensor_model_i.move(12);
        repeat (4) @(posedge clk_i);
        check("irq on leaving home", 32'h1, {31'h0, irq_o});
        wr(IRQ_CLR_OFS, 32'h1 << EV_HOME);
        repeat (2) @(posedge clk_i);
        check("irq after clear", 32'h0, {31'h0, irq_o});
        // Random moves out and back: one timing pulse per count, and the position returns to its start.
        repeat (3)
        begin
            a = ($random(seed) & 15) + 1;
            bus(1'b0, POSITION_OFS, 32'h0, '0, p0);
            pts_n = 0;
            carriage_sensor_model_i.move(a);
            bus(1'b0, POSITION_OFS, 32'h0, '0, p1);
            d = p1[15:0] - p0[15:0];
            check("step magnitude", a, {16'h0, d[15] ? -d : d});
            check("timing pulses", a, pts_n);
            carriage_sensor_model_i.move(-a);
            rd(POSITION_OFS, 32'hFFFF, p0 & 32'hFFFF);
        end
        $display("test encoder done");
        // Masked: re-entering home sets the sticky bit but leaves the line low.
        wr(IRQ_EN_OFS, 32'h0);
        carriage_sensor_model_i.move(-12);
        repeat (4) @(posedge clk_i);
        rd(IRQ_STAT_OFS, 32'h1 << EV_HOME, 32'h1 << EV_HOME);
        check("masked irq", 32'h0, {31'h0, irq_o});
        // Every gap code starts the cam at home, aborts off home and is refused there.
        for (int c = 0; c < 4; c++)
        begin
            wr(GAP_CMD_OFS, c);
            repeat (3) @(posedge clk_i);
            check("cam at home", 32'h1, {31'h0, motor_o.step_reverse});
            rd(GAP_CMD_OFS, 32'h800, 32'h0);
            carriage_sensor_model_i.move(12);
            wr(GAP_CMD_OFS, c);
            repeat (3) @(posedge clk_i);
            check("cam off home", 32'h0, {31'h0, motor_o.step_reverse});
            rd(GAP_CMD_OFS, 32'h800, 32'h800);
            carriage_sensor_model_i.move(-12);
        end
        $display("test gap done");
        // Run with a random target, then paper and platen readings with a chopped emitter.
        tgt = $random(seed);
        wr(TARGET_OFS, tgt);
        wr(CTRL_OFS, (32'h1 << CTRL_EDGE_EN) | 32'h1);
        repeat (3) @(posedge clk_i);
        check("motor direction", {31'h0, tgt[15]}, {31'h0, motor_o.cr_dir});
        wr(EDGE_CFG_OFS, 32'h80);
        carriage_sensor_model_i.paper <= 1'b1;
        toggles = 0;
        repeat (30000) @(posedge clk_i);
        check("emitter chopping", 32'h1, {31'h0, toggles >= 2});
        check("coarse fire period", CLK_HZ / 8640 + 1, fire_gap);
        rd(ADC_OFS, 32'hFF01, 32'h1001);
        rd(EDGE_POS_OFS, 32'h3, 32'h1);
        rd(IRQ_STAT_OFS, 32'h18, 32'h1 << EV_EDGE);
        // Finest waveform with skew monitoring: a paper change is a skew event, not a capture.
        carriage_sensor_model_i.paper <= 1'b0;
        wr(CTRL_OFS, (32'h1 << CTRL_EDGE_EN) | (32'h1 << CTRL_SKEW_EN)
                     | (32'h2 << CTRL_MODE_LSB) | 32'h1);
        repeat (30000) @(posedge clk_i);
        check("finest fire period", CLK_HZ / 6840 / 2 + 1, fire_gap);
        rd(ADC_OFS, 32'hFF01, 32'h1000);
        rd(EDGE_POS_OFS, 32'h3, 32'h1);
        rd(IRQ_STAT_OFS, 32'h1 << EV_SKEW, 32'h1 << EV_SKEW);
        // Sensing disabled: the emitter goes dark and the paper state is frozen.
        wr(CTRL_OFS, 32'h1);
        carriage_sensor_model_i.paper <= 1'b1;
        repeat (100) @(posedge clk_i);
        check("emitter when disabled", 32'h0, {31'h0, emit});
        rd(ADC_OFS, 32'h1, 32'h0);
        $display("test edge done");
        repeat (4) @(posedge clk_i);
        print_verdict();
    end
endmodule : test_carriage_gap_position_logic

// File: verilog/carriage_gap_pkg.sv
package carriage_gap_pkg;

    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] TARGET_OFS    = 8'h04;
    localparam logic [7:0] GAP_CMD_OFS   = 8'h08;
    localparam logic [7:0] EDGE_CFG_OFS  = 8'h0C;
    localparam logic [7:0] ADC_OFS       = 8'h10;
    localparam logic [7:0] POSITION_OFS  = 8'h14;
    localparam logic [7:0] STATUS_OFS    = 8'h18;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h1C;
    localparam logic [7:0] IRQ_CLR_OFS   = 8'h20;
    localparam logic [7:0] IRQ_EN_OFS    = 8'h24;
    localparam logic [7:0] EDGE_POS_OFS  = 8'h28;

    // Control register fields.
    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_INK_BIT    = 1;
    localparam int CTRL_MODE_LSB   = 2;
    localparam int CTRL_EDGE_EN    = 4;
    localparam int CTRL_SKEW_EN    = 5;

    // Interrupt event bit positions.
    localparam int EV_HOME     = 0;
    localparam int EV_GAP_DONE = 1;
    localparam int EV_GAP_ERR  = 2;
    localparam int EV_EDGE     = 3;
    localparam int EV_SKEW     = 4;
    localparam int EV_W        = 5;

    // Head-gap cam step positions from the origin, in two-phase steps.
    localparam logic [9:0] GAP_STEPS_LARGE  = 10'd37;
    localparam logic [9:0] GAP_STEPS_MEDIUM = 10'd121;
    localparam logic [9:0] GAP_STEPS_SMALL  = 10'd204;
    localparam logic [9:0] GAP_STEPS_FILM   = 10'd287;
    localparam logic [9:0] GAP_SEEK_LIMIT   = 10'd1000;
    localparam logic [31:0] GAP_ERR_CODE    = 32'h0001000C;

    // Timing: gap stepper pulse period and emitter chop period.
    localparam int CLK_HZ        = 125_000_000;
    localparam int STEP_US       = 2000;
    localparam int STEP_CYC      = CLK_HZ / 1_000_000 * STEP_US;
    localparam int CHOP_US       = 100;
    localparam int CHOP_CYC      = CLK_HZ / 1_000_000 * CHOP_US;

    // Carriage speed per waveform mode, in encoder counts per speed window.
    localparam logic [15:0] SPEED_FAST = 16'd240;
    localparam logic [15:0] SPEED_SLOW = 16'd190;

    // Reset values.
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [7:0]  THRESH_RST    = 8'h80;

    typedef enum {GAP_IDLE, GAP_SEEK, GAP_MOVE} gap_state_t;

    // Waveform mode: index into coarse, fine and finest waveforms.
    typedef enum logic [1:0] {
        COARSE_WAVEFORM,
        FINE_WAVEFORM,
        FINEST_WAVEFORM
    } wave_mode_t;

    // Motor drive outputs travel together.
    typedef struct packed {
        logic        cr_dir;
        logic [15:0] cr_duty;
        logic        step_pulse;
        logic        step_reverse;
    } motor_out_t;

endpackage : carriage_gap_pkg

// File: verilog/carriage_gap_position_logic.sv
`timescale 1ns/1ps
module carriage_gap_position_logic
    import carriage_gap_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // Carriage sensors.
    input  wire logic        carriage_home_sensor_i,
    input  wire logic        enc_a_i,
    input  wire logic        enc_b_i,
    input  wire logic        head_gap_home_sensor_i,
    input  wire logic [7:0]  edge_adc_i,
    input  wire logic        edge_adc_valid_i,
    // Drives.
    output logic             edge_emitter_o,
    output logic             print_timing_pulse_o,
    output motor_out_t       motor_o,
    output logic             waveform_fire_o
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0]      ctrl;
        logic [15:0]      target;
        logic [7:0]       thresh;
        logic [15:0]      pos;
        logic [1:0]       enc_ab;
        logic [15:0]      speed_cnt;
        logic [15:0]      speed;
        logic [23:0]      win_cnt;
        logic             home_prev;
        gap_state_t       gst;
        logic [9:0]       gap_pos;
        logic [9:0]       gap_goal;
        logic [9:0]       seek_cnt;
        logic [31:0]      step_cnt;
        logic [31:0]      err_code;
        logic [15:0]      chop_cnt;
        logic             emit;
        logic [7:0]       dark;
        logic             paper;
        logic [1:0]       edge_idx;
        logic [63:0]      edges;
        logic [EV_W-1:0]  ist;
        logic [EV_W-1:0]  ien;
        logic [15:0]      duty;
        logic             print_timing_pulse;
        logic [15:0]      fire_cnt;
        logic             fire;
        logic             ack;
        logic [31:0]      rdat;
    } state_t;

    state_t st_q;
    state_t st_d;

    // Converts a gap selection code to its cam step count.
    function automatic logic [9:0] gap_steps(input logic [1:0] sel);
        case (sel)
            2'd0:    gap_steps = GAP_STEPS_LARGE;
            2'd1:    gap_steps = GAP_STEPS_MEDIUM;
            2'd2:    gap_steps = GAP_STEPS_SMALL;
            default: gap_steps = GAP_STEPS_FILM;
        endcase
    endfunction : gap_steps

    logic       at_home;
    logic       wr;
    logic       rd_ok;
    logic [1:0] ab_now;
    logic       inc;
    logic       dec;
    wave_mode_t mode;
    logic [15:0] fire_div;
    logic [EV_W-1:0] ev;

    // Home range reads low on the sensor.
    assign at_home = !carriage_home_sensor_i;
    assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && !st_q.ack;
    assign ab_now  = {enc_a_i, enc_b_i};
    assign mode    = wave_mode_t'(st_q.ctrl[CTRL_MODE_LSB +: 2]);

    // Gray sequence 00-01-11-10 counts up, reversed counts down.
    always_comb
    begin
        inc = 1'b0;
        dec = 1'b0;
        case ({st_q.enc_ab, ab_now})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: inc = 1'b1;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: dec = 1'b1;
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole block.
    always_comb
    begin
        st_d = st_q;
        ev = '0;
        st_d.print_timing_pulse = 1'b0;
        st_d.fire = 1'b0;
        st_d.enc_ab = ab_now;
        // Quadrature position and the print timing pulse.
        if (inc || dec)
        begin
            st_d.pos = inc ? st_q.pos + 16'd1 : st_q.pos - 16'd1;
            st_d.print_timing_pulse = 1'b1;
            st_d.speed_cnt = st_q.speed_cnt + 16'd1;
        end
        // Position zero is the home flag edge in either direction.
        st_d.home_prev = carriage_home_sensor_i;
        if (carriage_home_sensor_i != st_q.home_prev)
        begin
            st_d.pos = '0;
            ev[EV_HOME] = 1'b1;
        end
        // Speed window of 1 ms; duty steps by one count toward target.
        st_d.win_cnt = st_q.win_cnt + 24'd1;
        if (st_q.win_cnt == 24'(CLK_HZ / 1000 - 1))
        begin
            st_d.win_cnt = '0;
            st_d.speed = st_q.speed_cnt;
            st_d.speed_cnt = '0;
            if (!st_q.ctrl[CTRL_RUN_BIT])
                st_d.duty = '0;
            else if (st_q.speed_cnt < st_q.target && st_q.duty != 16'hFFFF)
                st_d.duty = st_q.duty + 16'd1;
            else if (st_q.speed_cnt > st_q.target && st_q.duty != 16'h0000)
                st_d.duty = st_q.duty - 16'd1;
        end
        // Firing clock follows the waveform mode; finest runs faster.
        st_d.fire_cnt = st_q.fire_cnt + 16'd1;
        if (st_q.fire_cnt >= fire_div)
        begin
            st_d.fire_cnt = '0;
            st_d.fire = st_q.ctrl[CTRL_RUN_BIT];
        end
        // Gap cam sequencer: seek origin then step to the goal.
        st_d.step_cnt = (st_q.step_cnt == 32'(STEP_CYC - 1)) ? '0 : st_q.step_cnt + 32'd1;
        case (st_q.gst)
            GAP_IDLE: ;
            GAP_SEEK:
            begin
                if (!at_home)
                    st_d.gst = GAP_IDLE;
                else if (head_gap_home_sensor_i)
                begin
                    st_d.gap_pos = '0;
                    st_d.gst = GAP_MOVE;
                end
                else if (st_q.seek_cnt > GAP_SEEK_LIMIT)
                begin
                    st_d.err_code = GAP_ERR_CODE;
                    ev[EV_GAP_ERR] = 1'b1;
                    st_d.gst = GAP_IDLE;
                end
                else if (st_q.step_cnt == '0)
                    st_d.seek_cnt = st_q.seek_cnt + 10'd1;
            end
            GAP_MOVE:
            begin
                if (!at_home)
                    st_d.gst = GAP_IDLE;
                else if (st_q.gap_pos == st_q.gap_goal)
                begin
                    ev[EV_GAP_DONE] = 1'b1;
                    st_d.gst = GAP_IDLE;
                end
                else if (st_q.step_cnt == '0)
                    st_d.gap_pos = st_q.gap_pos + 10'd1;
            end
            default: st_d.gst = GAP_IDLE;
        endcase
        // Emitter chop; dark sample taken with emitter off.
        st_d.chop_cnt = st_q.chop_cnt + 16'd1;
        if (st_q.chop_cnt == 16'(CHOP_CYC - 1))
        begin
            st_d.chop_cnt = '0;
            st_d.emit = !st_q.emit;
        end
        // Disabling edge sensing darkens the emitter at once rather than at the next
        // chop boundary, so a lamp is never left lit for up to a whole chop period.
        if (!st_q.ctrl[CTRL_EDGE_EN])
            st_d.emit = 1'b0;
        if (edge_adc_valid_i && st_q.ctrl[CTRL_EDGE_EN])
        begin
            if (!st_q.emit)
                st_d.dark = edge_adc_i;
            else
            begin
                // Ambient-corrected reflection compared with the threshold.
                st_d.paper = (edge_adc_i > st_q.dark) &&
                             ((edge_adc_i - st_q.dark) > st_q.thresh);
                if (st_d.paper != st_q.paper)
                begin
                    if (st_q.ctrl[CTRL_SKEW_EN])
                        ev[EV_SKEW] = 1'b1;
                    else
                    begin
                        st_d.edges[st_q.edge_idx*16 +: 16] = st_q.pos;
                        st_d.edge_idx = st_q.edge_idx + 2'd1;
                        ev[EV_EDGE] = 1'b1;
                    end
                end
            end
        end
        // Wishbone register writes; cleared in a single cycle ack.
        st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
        if (wr)
        begin
            case (wb_adr_i)
                CTRL_OFS:     st_d.ctrl = wb_dat_i;
                TARGET_OFS:   st_d.target = wb_dat_i[15:0];
                GAP_CMD_OFS:
                if (at_home)
                begin
                    st_d.gap_goal = gap_steps(wb_dat_i[1:0]);
                    st_d.seek_cnt = '0;
                    st_d.err_code = '0;
                    st_d.gst = GAP_SEEK;
                end
                EDGE_CFG_OFS: begin st_d.thresh = wb_dat_i[7:0]; st_d.edge_idx = '0; end
                IRQ_CLR_OFS:  st_d.ist = st_q.ist & ~wb_dat_i[EV_W-1:0];
                IRQ_EN_OFS:   st_d.ien = wb_dat_i[EV_W-1:0];
                default: ;
            endcase
        end
        // Events set after the clear so a coincident event survives.
        st_d.ist = st_d.ist | ev;
        // Read mux, registered with the ack.
        case (wb_adr_i)
            CTRL_OFS:     st_d.rdat = st_q.ctrl;
            TARGET_OFS:   st_d.rdat = {16'h0000, st_q.target};
            GAP_CMD_OFS:  st_d.rdat = {20'h00000, st_q.gst == GAP_IDLE, 1'b0, st_q.gap_pos};
            EDGE_CFG_OFS: st_d.rdat = {24'h000000, st_q.thresh};
            ADC_OFS:      st_d.rdat = {16'h0000, st_q.dark, 7'h00, st_q.paper};
            POSITION_OFS: st_d.rdat = {st_q.speed, st_q.pos};
            STATUS_OFS:   st_d.rdat = st_q.err_code;
            IRQ_STAT_OFS: st_d.rdat = {27'h0000000, st_q.ist};
            IRQ_EN_OFS:   st_d.rdat = {27'h0000000, st_q.ien};
            EDGE_POS_OFS: st_d.rdat = {st_q.edges[st_q.edge_idx*16 +: 16], 14'h0000, st_q.edge_idx};
            default:      st_d.rdat = '0;
        endcase
    end

    // Firing divider per mode: coarse and fine share a rate, finest is faster.
    always_comb
    begin
        case (mode)
            FINEST_WAVEFORM: fire_div = 16'(CLK_HZ / 6840 / 2);
            default:         fire_div = 16'(CLK_HZ / 8640);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
            st_q.ctrl <= CTRL_RST;
            st_q.thresh <= THRESH_RST;
            st_q.gst <= GAP_IDLE;
        end
        else
            st_q <= st_d;
    end

    // Outputs from flops, handshake too; irq and stepper lines decoded from flops.
    assign wb_dat_o             = st_q.rdat;
    assign wb_ack_o             = st_q.ack;
    assign irq_o                = |(st_q.ist & st_q.ien);
    assign edge_emitter_o       = st_q.emit;
    assign print_timing_pulse_o = st_q.print_timing_pulse;
    assign waveform_fire_o      = st_q.fire;
    assign motor_o.cr_dir       = st_q.target[15];
    assign motor_o.cr_duty      = st_q.duty;
    assign motor_o.step_pulse   = (st_q.gst != GAP_IDLE) && (st_q.step_cnt < 32'(STEP_CYC / 2));
    assign motor_o.step_reverse = (st_q.gst != GAP_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Cam checks. The stepper gear only engages the cam at home, so a cam move
    // that outlives the carriage leaving home would turn the pump instead.
    AST_CAM_AT_HOME: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.gst != GAP_IDLE && !at_home) |=> !motor_o.step_reverse)
        else $error("cam moved away from home");
    // The flag clears the step count so every goal is measured from the origin.
    AST_GAP_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.gst == GAP_SEEK && at_home && head_gap_home_sensor_i) |=> st_q.gap_pos == 10'd0)
        else $error("gap counter not cleared");
    // A seek that runs past its limit must leave the service code behind.
    AST_SEEK_ERR: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.gst == GAP_SEEK && at_home && !head_gap_home_sensor_i
         && st_q.seek_cnt > GAP_SEEK_LIMIT) |=> st_q.err_code == 32'h0001000C)
        else $error("seek error code missing");
    // Reaching the goal ends the move and leaves a sticky event.
    AST_GAP_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q.gst == GAP_MOVE && at_home && st_q.gap_pos == st_q.gap_goal) |=>
        st_q.gst == GAP_IDLE && st_q.ist[EV_GAP_DONE])
        else $error("gap done lost");

    // Carriage position checks.
    AST_POS_HOME: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(carriage_home_sensor_i) |=> st_q.pos == 16'd0)
        else $error("home not zero");
    AST_PTS: assert property (@(posedge clk_i) disable iff (rst_i)
        (inc || dec) |=> print_timing_pulse_o)
        else $error("timing pulse missing");
    AST_QUAD_UP: assert property (@(posedge clk_i) disable iff (rst_i)
        (inc && $stable(carriage_home_sensor_i)) |=> st_q.pos == $past(st_q.pos) + 16'd1)
        else $error("count up wrong");

    // Edge sensor and firing checks.
    AST_EMIT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_q.ctrl[CTRL_EDGE_EN] |=> !edge_emitter_o)
        else $error("emitter on while disabled");
    AST_EDGE_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_q.ctrl[CTRL_EDGE_EN] |=> $stable(st_q.paper))
        else $error("paper state moved while disabled");
    AST_FIRE_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
        waveform_fire_o |-> $past(st_q.ctrl[CTRL_RUN_BIT]))
        else $error("firing while not running");

endmodule : carriage_gap_position_logic
